// ---- logic/hioc_top.sv ----
// Host interrupt pin controller: status, enables, hold-off and pin driver.
`timescale 1ns/1ns

`include "hioc_params.svh"

////////////////////////////////////////////////////////////////////////////////
// How it works
// [R1] Eight-bit hold-off field sets withhold time in 10 us steps; resets to zero.
// [R2] Writing zero hold-off stops the interval, clears counter, releases pending requests.
// [R3] A new non-zero hold-off length applies to every following interrupt.
// [R4] The power event interrupt is never held off.
// [R5] Writing one to the restart bit clears the counter and begins a new interval.
// [R6] Active flag reads one while withheld, clears itself when the interval ends.
// [R7] Master bit shows the combined enabled line, ignoring output enable and hold-off.
// [R8] With output enable clear the pin stays deasserted; status keeps updating.
// [R9] Polarity bit: zero active low, one active high; survives software reset.
// [R10] Type bit: zero open-drain, one push-pull; resets to zero, survives software reset.
// [R11] In open-drain mode polarity is ignored and the pin asserts low.
// [R12] Writing one to a status bit clears it; writing zero leaves it.
// [R13] Master line is OR of status AND enable; expiry re-presents active requests.
// [R14] Prescaler makes the 10 us base; any reset clears the interval counter.
module hioc_top
	import hioc_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic soft_rst,
	input wire hioc_bus_t bus_req,
	output logic [31:0] rd_data,
	input wire logic [31:0] irq_events,
	output logic irq_pin_out,
	output logic irq_pin_oe_n
);

	////////////////////////////////////////////////////////////////////////////////
	// Address decode.

	function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] off);
		addr_hit = (addr == off);
	endfunction : addr_hit

	wire cfg_sel = addr_hit(bus_req.addr, `HIOC_OFF_CFG);
	wire sts_sel = addr_hit(bus_req.addr, `HIOC_OFF_STS);
	wire en_sel = addr_hit(bus_req.addr, `HIOC_OFF_EN);
	wire cfg_wr = bus_req.wr && cfg_sel;
	wire sts_wr = bus_req.wr && sts_sel;
	wire en_wr = bus_req.wr && en_sel;

	////////////////////////////////////////////////////////////////////////////////
	// Configuration register.

	hioc_cfg_t cfg_q;
	hioc_cfg_t cfg_d;
	hioc_cfg_t cfg_wval;

	assign cfg_wval.holdoff_interval = bus_req.wdata[`HIOC_CFG_HOLD_HI:`HIOC_CFG_HOLD_LO]; // R1
	assign cfg_wval.out_en = bus_req.wdata[`HIOC_CFG_OUT_EN];
	assign cfg_wval.pin_polarity = bus_req.wdata[`HIOC_CFG_POL];
	assign cfg_wval.push_pull = bus_req.wdata[`HIOC_CFG_TYPE];

	wire holdoff_restart = cfg_wr && bus_req.wdata[`HIOC_CFG_RESTART]; // R5

	// Software reset clears the withhold settings but leaves the pin shape alone,
	// so a shared open-drain line never glitches into a driven level.
	always_comb
	begin
		cfg_d = cfg_q;
		if (cfg_wr)
		begin
			cfg_d = cfg_wval;
		end
		if (soft_rst)
		begin
			cfg_d.holdoff_interval = `HIOC_HOLD_RESET; // R1
			cfg_d.out_en = 1'b0; // R8
			cfg_d.pin_polarity = cfg_q.pin_polarity; // R9
			cfg_d.push_pull = cfg_q.push_pull; // R10
		end
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cfg_q <= '0;
		end
		else
		begin
			cfg_q <= cfg_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Status and enable registers.

	logic [31:0] sts_q;
	logic [31:0] sts_d;
	logic [31:0] en_q;
	logic [31:0] en_d;
	wire [31:0] ack_mask = sts_wr ? bus_req.wdata : 32'h00000000;

	genvar gi;
	generate
		for (gi = 0; gi < 32; gi++)
		begin : g_sts
			// A new event in the same cycle as its acknowledge wins.
			assign sts_d[gi] = soft_rst ? irq_events[gi]
				: (irq_events[gi] || (sts_q[gi] && !ack_mask[gi])); // R12
		end
	endgenerate

	assign en_d = soft_rst ? `HIOC_EN_RESET : (en_wr ? bus_req.wdata : en_q);

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sts_q <= `HIOC_STS_RESET;
			en_q <= `HIOC_EN_RESET;
		end
		else
		begin
			sts_q <= sts_d;
			en_q <= en_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Combined request lines.

	localparam logic [31:0] PWR_MASK = 32'h00000001 << `HIOC_PWR_EVT_BIT;

	wire [31:0] live = sts_q & en_q;
	wire master_line = |live; // R7 R13
	wire power_event = |(live & PWR_MASK); // R4
	wire held_line = |(live & ~PWR_MASK); // R13

	////////////////////////////////////////////////////////////////////////////////
	// Hold-off timing.

	logic holdoff_active;
	logic held_drive_q;

	// The withheld sources reach the pin only outside an interval.
	wire held_drive = cfg_q.out_en && held_line && !holdoff_active; // R6 R13
	// A new interval opens as soon as the held request leaves the pin.
	wire interval_start = held_drive_q && !held_drive && (cfg_q.holdoff_interval != 8'h00);

	hioc_holdoff_timer u_timer (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.soft_clr(soft_rst),
		.holdoff_interval(cfg_q.holdoff_interval),
		.start(interval_start),
		.holdoff_restart(holdoff_restart),
		.holdoff_active(holdoff_active)
	);

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			held_drive_q <= 1'b0;
		end
		else
		begin
			held_drive_q <= held_drive;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pin driver.

	wire pin_assert = cfg_q.out_en && (power_event || held_drive); // R8 R4
	// Open-drain drives low only while asserted; push-pull drives always.
	wire pin_level = cfg_q.push_pull ? (cfg_q.pin_polarity ? pin_assert : !pin_assert)
		: 1'b0; // R9 R11
	wire pin_oe_n = cfg_q.push_pull ? 1'b0 : !pin_assert; // R10 R11

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			irq_pin_out <= 1'b0;
			irq_pin_oe_n <= 1'b1;
		end
		else
		begin
			irq_pin_out <= pin_level;
			irq_pin_oe_n <= pin_oe_n;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read data, valid in the cycle after the read strobe.

	logic [31:0] cfg_rd;

	always_comb
	begin
		cfg_rd = 32'h00000000;
		cfg_rd[`HIOC_CFG_HOLD_HI:`HIOC_CFG_HOLD_LO] = cfg_q.holdoff_interval;
		cfg_rd[`HIOC_CFG_ACTIVE] = holdoff_active; // R6
		cfg_rd[`HIOC_CFG_MASTER] = master_line; // R7
		cfg_rd[`HIOC_CFG_OUT_EN] = cfg_q.out_en;
		cfg_rd[`HIOC_CFG_POL] = cfg_q.pin_polarity;
		cfg_rd[`HIOC_CFG_TYPE] = cfg_q.push_pull;
	end

	wire [31:0] rd_mux = cfg_sel ? cfg_rd
		: sts_sel ? sts_q
		: en_sel ? en_q
		: 32'h00000000;

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rd_data <= 32'h00000000;
		end
		else
		begin
			rd_data <= bus_req.rd ? rd_mux : 32'h00000000;
		end
	end

endmodule : hioc_top

// ---- inc/hioc_params.svh ----
// Register offsets, field positions, reset values and timing counts of the host interrupt block.
`ifndef HIOC_PARAMS_SVH
`define HIOC_PARAMS_SVH

`define HIOC_OFF_CFG 8'h54
`define HIOC_OFF_STS 8'h58
`define HIOC_OFF_EN 8'h5C

`define HIOC_CFG_HOLD_HI 31
`define HIOC_CFG_HOLD_LO 24
`define HIOC_CFG_RESTART 14
`define HIOC_CFG_ACTIVE 13
`define HIOC_CFG_MASTER 12
`define HIOC_CFG_OUT_EN 8
`define HIOC_CFG_POL 4
`define HIOC_CFG_TYPE 0

`define HIOC_PWR_EVT_BIT 17
`define HIOC_CFG_RESET 32'h00000000
`define HIOC_STS_RESET 32'h00000000
`define HIOC_EN_RESET 32'h00000000
`define HIOC_HOLD_RESET 8'h00

`define HIOC_STEP_NS 10000
`define HIOC_CLK_NS 10
`define HIOC_STEP_CYC (`HIOC_STEP_NS / `HIOC_CLK_NS)

`endif

// ---- inc/hioc_pkg.sv ----
// Types shared by the host interrupt output block.
package hioc_pkg;

	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} hioc_bus_t;

	typedef struct packed {
		logic [7:0] holdoff_interval;
		logic out_en;
		logic pin_polarity;
		logic push_pull;
	} hioc_cfg_t;

	typedef enum logic [0:0] {
		HIOC_IDLE,
		HIOC_HOLD
	} hioc_hold_state_t;

endpackage : hioc_pkg

// ---- logic/hioc_holdoff_timer.sv ----
// Hold-off interval timer: 10 us prescaler and interval counter.
`timescale 1ns/1ns

`include "hioc_params.svh"

module hioc_holdoff_timer
	import hioc_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic soft_clr,
	input wire logic [7:0] holdoff_interval,
	input wire logic start,
	input wire logic holdoff_restart,
	output logic holdoff_active
);

	localparam logic [9:0] STEP_LAST = 10'(`HIOC_STEP_CYC - 1);

	hioc_hold_state_t state_q;
	hioc_hold_state_t state_d;
	logic [9:0] pre_q;
	logic [9:0] pre_d;
	logic [7:0] cnt_q;
	logic [7:0] cnt_d;

	wire tick = (state_q == HIOC_HOLD) && (pre_q == STEP_LAST);
	wire zero_hold = (holdoff_interval == 8'h00);
	wire kick = start || holdoff_restart;
	// The limit is read live, so a newly written length governs the running interval too.
	wire last_step = ({1'b0, cnt_q} + 9'h001) >= {1'b0, holdoff_interval};

	always_comb
	begin
		state_d = state_q;
		pre_d = pre_q;
		cnt_d = cnt_q;
		case (state_q)
			HIOC_IDLE:
			begin
				pre_d = 10'h000;
				cnt_d = 8'h00;
			end
			HIOC_HOLD:
			begin
				pre_d = tick ? 10'h000 : pre_q + 10'h001; // R14
				if (tick)
				begin
					cnt_d = cnt_q + 8'h01;
					if (last_step)
					begin
						state_d = HIOC_IDLE; // R6
					end
				end
			end
			default:
			begin
				state_d = HIOC_IDLE;
			end
		endcase
		if (kick)
		begin
			state_d = HIOC_HOLD; // R5 R3
			pre_d = 10'h000;
			cnt_d = 8'h00;
		end
		if (zero_hold || soft_clr)
		begin
			state_d = HIOC_IDLE; // R2 R14
			pre_d = 10'h000;
			cnt_d = 8'h00;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q <= HIOC_IDLE;
			pre_q <= 10'h000;
			cnt_q <= 8'h00;
		end
		else
		begin
			state_q <= state_d;
			pre_q <= pre_d;
			cnt_q <= cnt_d;
		end
	end

	assign holdoff_active = (state_q == HIOC_HOLD); // R6

endmodule : hioc_holdoff_timer

// ---- verif/hioc_properties.sv ----
// Concurrent checks on the ports of the host interrupt pin controller.
`timescale 1ns/1ns
module hioc_chk
	import hioc_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic soft_rst,
	input wire hioc_bus_t bus_req,
	input wire logic [31:0] rd_data,
	input wire logic [31:0] irq_events,
	input wire logic irq_pin_out,
	input wire logic irq_pin_oe_n
);
	default clocking dc @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);
	// Shadow of the configuration, so pin checks know the mode the design runs in.
	logic [7:0] hold_q;
	logic oe_q, pol_q, pp_q, en_q;
	wire [31:0] wd = bus_req.wdata;
	wire rcfg = bus_req.rd && bus_req.addr == 8'h54;
	wire rd_unm = bus_req.rd && !(bus_req.addr inside {8'h54, 8'h58, 8'h5C});
	wire [10:0] cfgv = {hold_q, oe_q, pol_q, pp_q};
	wire [10:0] rd_cfgv = {rd_data[31:24], rd_data[8], rd_data[4], rd_data[0]};
	wire quiet = pp_q ? (!irq_pin_oe_n && irq_pin_out != pol_q) : irq_pin_oe_n;
	wire live = en_q && oe_q && pp_q && pol_q && !soft_rst;
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			{hold_q, oe_q, pol_q, pp_q, en_q} <= 12'h000;
		else if (soft_rst)
			{hold_q, oe_q, en_q} <= 10'h000;
		else
		begin
			if (bus_req.wr && bus_req.addr == 8'h54)
				{hold_q, oe_q, pol_q, pp_q} <= {wd[31:24], wd[8], wd[4], wd[0]};
			if (bus_req.wr && bus_req.addr == 8'h5C)
				en_q <= wd[17];
		end
	end
	////////////////////////////////
	AST_OFF_QUIET: assert property (!oe_q ##1 $stable(cfgv) |-> quiet)
		else $error("pin asserted while output disabled");
	AST_PP_DRIVE: assert property (pp_q ##1 $stable(cfgv) |-> !irq_pin_oe_n)
		else $error("push-pull pin not driven");
	AST_OD_LOW: assert property (!pp_q ##1 $stable(cfgv) |-> !irq_pin_out)
		else $error("open-drain pin drives high");
	AST_PWR_PASS: assert property (irq_events[17] && live ##1 live |=> irq_pin_out)
		else $error("power event held off");
	AST_CFG_RD: assert property ($past(rcfg) |-> rd_cfgv == $past(cfgv))
		else $error("config readback wrong");
	AST_RESTART_RD: assert property ($past(rcfg) |-> !rd_data[14])
		else $error("restart bit reads one");
	AST_HOLD_ZERO: assert property ($past(rcfg) && $past(hold_q, 2) == 8'h00
		&& $past(hold_q) == 8'h00 |-> !rd_data[13])
		else $error("interval active with zero hold-off");
	AST_UNMAP: assert property ($past(rd_unm) |-> rd_data == 32'h0)
		else $error("unmapped read not zero");
	cover property (live ##2 irq_pin_out);
	cover property (rcfg ##1 rd_data[13]);
	cover property (!pp_q && !irq_pin_oe_n);
endmodule : hioc_chk
bind hioc_top hioc_chk u_hioc_chk (.core_clk(core_clk), .rst_n(rst_n), .soft_rst(soft_rst),
	.bus_req(bus_req), .rd_data(rd_data), .irq_events(irq_events), .irq_pin_out(irq_pin_out),
	.irq_pin_oe_n(irq_pin_oe_n));

// ---- verif/hioc_host_model.sv ----
// Host side of the interrupt line: pull-up and level detector.
`timescale 1ns/1ns
module hioc_host_model
(
	input wire logic pin_out,
	input wire logic pin_oe_n,
	input wire logic act_hi,
	output logic lvl,
	output logic seen
);
	// The line is shared and pulled up, so a released pin reads high.
	assign lvl = pin_oe_n ? 1'b1 : pin_out;
	assign seen = lvl == act_hi;
endmodule : hioc_host_model

// ---- verif/tb_hioc_top.sv ----
// Self-checking bench of the host interrupt pin controller.
`timescale 1ns/1ns
module tb_hioc_top
	import hioc_pkg::*;
;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic soft_rst = 1'b0;
	logic act_hi = 1'b0;
	hioc_bus_t bus_req = '0;
	logic [31:0] irq_events = 32'h0;
	logic [31:0] rd_data, v, e, m;
	logic pin_out, oe_n, lvl, seen;
	int mismatches = 0;
	int tests_run = 0;
	int cyc = 0;
	logic [7:0] adr [4] = '{8'h54, 8'h58, 8'h5C, 8'h60};
	hioc_top u_hioc_top (.core_clk(core_clk), .rst_n(rst_n), .soft_rst(soft_rst),
		.bus_req(bus_req), .rd_data(rd_data), .irq_events(irq_events),
		.irq_pin_out(pin_out), .irq_pin_oe_n(oe_n));
	hioc_host_model u_hioc_host_model (.pin_out(pin_out), .pin_oe_n(oe_n), .act_hi(act_hi),
		.lvl(lvl), .seen(seen));
	always #5 core_clk = ~core_clk;
	always @(posedge core_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			mismatches++;
			wrap_up();
		end
	end
	////////////////////////////////
	// Flags are {active, master, out_en, polarity, push_pull}.
	function automatic logic [31:0] cfg_exp(input logic [7:0] h, input logic [4:0] f);
		return {h, 10'h000, f[4:3], 3'h0, f[2], 3'h0, f[1], 3'h0, f[0]};
	endfunction : cfg_exp
	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		tests_run++;
		if (s !== x)
		begin
			mismatches++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, x);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		bus_req <= '{a, d, 1'b1, 1'b0};
		@(posedge core_clk);
		bus_req.wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge core_clk);
		bus_req <= '{a, 32'h0, 1'b0, 1'b1};
		@(posedge core_clk);
		bus_req.rd <= 1'b0;
		@(negedge core_clk);
		d = rd_data;
	endtask : rd
	task automatic ev(input logic [31:0] x);
		@(posedge core_clk);
		irq_events <= x;
		@(posedge core_clk);
		irq_events <= 32'h0;
	endtask : ev
	// Pin follows status one edge late; the second and third edges leave margin.
	// The pin is looked at on the falling edge, where it has settled.
	task automatic pin(input logic x);
		repeat (3) @(posedge core_clk);
		@(negedge core_clk);
		chk(32'(seen), 32'(x));
	endtask : pin
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : wrap_up
	////////////////////////////////
	initial
	begin
		v = $urandom(32'h129D5498);
		repeat (12) @(posedge core_clk);
		rst_n <= 1'b1;
		foreach (adr[i])
		begin
			rd(adr[i], v);
			chk(v, 32'h0);
		end
		e = $urandom;
		m = $urandom;
		ev(e);
		rd(8'h58, v);
		chk(v, e);
		wr(8'h58, m);
		wr(8'h58, 32'h0);
		rd(8'h58, v);
		chk(v, e & ~m);
		wr(8'h58, 32'hFFFFFFFF);
		$display("reset and status tests done");
		wr(8'h5C, 32'h00020001);
		ev(32'h1);
		rd(8'h54, v);
		chk(v, cfg_exp(8'h0, 5'h08));
		pin(1'b0);
		act_hi = 1'b1;
		wr(8'h54, cfg_exp(8'h1, 5'h07));
		pin(1'b1);
		wr(8'h58, 32'h1);
		pin(1'b0);
		rd(8'h54, v);
		chk(v, cfg_exp(8'h1, 5'h17));
		ev(32'h1);
		pin(1'b0);
		repeat (960) @(posedge core_clk);
		pin(1'b0);
		repeat (40) @(posedge core_clk);
		pin(1'b1);
		wr(8'h58, 32'h1);
		ev(32'h1);
		pin(1'b0);
		wr(8'h54, cfg_exp(8'h0, 5'h07));
		pin(1'b1);
		wr(8'h54, cfg_exp(8'h1, 5'h07));
		wr(8'h58, 32'h1);
		ev(32'h00020001);
		pin(1'b1);
		wr(8'h58, 32'h00020000);
		pin(1'b0);
		repeat (600) @(posedge core_clk);
		wr(8'h54, cfg_exp(8'h1, 5'h07) | 32'h00004000);
		repeat (600) @(posedge core_clk);
		pin(1'b0);
		repeat (450) @(posedge core_clk);
		pin(1'b1);
		$display("hold-off tests done");
		act_hi = 1'b0;
		wr(8'h54, cfg_exp(8'h0, 5'h06));
		pin(1'b1);
		chk(32'(lvl), 32'h0);
		wr(8'h58, 32'hFFFFFFFF);
		pin(1'b0);
		wr(8'h54, cfg_exp(8'h3, 5'h07));
		@(posedge core_clk);
		soft_rst <= 1'b1;
		@(posedge core_clk);
		soft_rst <= 1'b0;
		rd(8'h54, v);
		chk(v, cfg_exp(8'h0, 5'h03));
		$display("pin mode tests done");
		wrap_up();
	end
endmodule : tb_hioc_top
